//--- core/bcos_pkg.sv
// What this block does
// - Idle with stop_in_idle 0 keeps running
// - Idle with stop_in_idle 1 halts like sleep but keeps text
// - Sleep entry resets sequencer, discards text
// - Operation 0000 selects block encryption
// - Operation 0001 selects block decryption
// - Key of length n uses low n bits
// - Key config error blocks encrypt or decrypt
// - DES block 64 bits, AES 128 bits
// - Done interrupt as hardware clears go
// - ECB/CBC input consumed raises free interrupt
// - DES decrypt reads low 64 of second text
// - Decrypt inserts key expansion when keys changed
// - ECB/CBC session keys limited to 128 bits
// - Session enable bars stored key 1 use
// - Session enable raises no mode error for session key into first
// - Operation 1110 encrypts session key into text
// - Operation 1111 decrypts text into key space
// - Long session keys done in two halves
// - Key source 0000 selects session key
// - Counter-mode generation barred by key disable
// - AES counter mode: op 0000, cipher 1, 100
// - Software clearing go aborts, sets abort flag
// - Go set only when no errors pending
// - Go ignored when disabled or with write
package bcos_pkg;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG  = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_TXTA = 8'h10;
	localparam logic [7:0] ADDR_TXTB = 8'h20;
	localparam logic [7:0] ADDR_TXTC = 8'h30;
	localparam logic [7:0] ADDR_KEY  = 8'h40;

	// Control word bit positions
	localparam int CTRL_ENABLE  = 15;
	localparam int CTRL_SIDL    = 13;
	localparam int CTRL_DONE_IRQ_ENABLE  = 11;
	localparam int CTRL_INPUT_FREE_IRQ_ENABLE  = 10;
	localparam int CTRL_GO      = 8;
	localparam int CTRL_OP_LSB  = 4;
	localparam int CTRL_CSEL    = 3;
	localparam int CTRL_CM_LSB  = 0;
	// Config word bit positions
	localparam int CFG_KSRC_LSB = 0;
	localparam int CFG_KLEN_LSB = 4;
	localparam int CFG_SKSEL    = 6;
	localparam int CFG_SESSION_KEY_ENABLE   = 7;
	localparam int CFG_SWKDIS   = 8;
	localparam int CFG_WR       = 9;
	localparam int CFG_RD       = 10;
	// Status word bit positions
	localparam int STAT_ABORT   = 0;
	localparam int STAT_ROLL    = 1;
	localparam int STAT_MODF    = 2;
	localparam int STAT_KEYF    = 3;
	localparam int STAT_BUSY    = 4;

	localparam logic [3:0] OP_ENC    = 4'h0;
	localparam logic [3:0] OP_DEC    = 4'h1;
	localparam logic [3:0] OP_KEXP   = 4'h2;
	localparam logic [3:0] OP_SK_ENC = 4'hE;
	localparam logic [3:0] OP_SK_DEC = 4'hF;
	localparam logic [2:0] CM_ECB    = 3'h0;
	localparam logic [2:0] CM_CBC    = 3'h1;
	localparam logic [2:0] CM_CTR    = 3'h4;
	localparam logic [3:0] KSRC_SESSION = 4'h0;
	localparam logic [3:0] KSRC_STORED1 = 4'h1;
	localparam logic [1:0] KLEN_DES  = 2'h0;
	localparam logic [1:0] KLEN_128  = 2'h1;

	localparam int DES_BITS = 64;
	localparam int AES_BITS = 128;
	localparam logic [5:0] CYC_DES  = 6'h10;
	localparam logic [5:0] CYC_AES  = 6'h0E;
	localparam logic [5:0] CYC_KEXP = 6'h0A;
	localparam logic [5:0] CYC_FREE = 6'h02;

	typedef enum logic [1:0] {
		BCOS_IDLE,
		BCOS_EXPAND,
		BCOS_RUN
	} bcos_state_e;

	typedef struct packed {
		logic       enable;
		logic       stop_in_idle;
		logic       done_ie;
		logic       free_ie;
		logic [3:0] op;
		logic       cipher;
		logic [2:0] chain;
	} bcos_ctrl_s;

	typedef struct packed {
		logic       storage_read;
		logic       storage_write;
		logic       sw_key_dis;
		logic       sk_enable;
		logic       sk_half;
		logic [1:0] key_len;
		logic [3:0] key_src;
	} bcos_cfg_s;

endpackage : bcos_pkg

//--- core/bcos_sequencer.sv
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module bcos_sequencer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        idle_mode_i,
	input  wire logic        sleep_mode_i,
	input  wire logic        core_done_i,
	output logic             core_start_o,
	output logic      [3:0]  core_op_o,
	output logic             core_dec_bottom_o,
	output logic      [7:0]  core_key_bits_o,
	output logic             done_irq_o,
	output logic             free_irq_o
);

	bcos_pkg::bcos_ctrl_s   ctrl_reg;
	bcos_pkg::bcos_cfg_s    cfg_reg;
	bcos_pkg::bcos_state_e  state_reg;
	logic                   go_reg;
	logic                   abort_reg;
	logic                   mode_err_reg;
	logic                   need_exp_reg;
	logic [5:0]             cnt_reg;
	logic [31:0]            text_reg [0:11];
	logic [31:0]            key_reg  [0:7];
	logic                   idle_s1_reg, idle_s2_reg, sleep_s1_reg, sleep_s2_reg;
	logic                   ack_reg;
	logic                   free_sent_reg;

	////////////////////////////////////////////////////////////////////
	// Byte-lane merge
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Key length in bits
	function automatic logic [8:0] key_bits(input logic [1:0] len);
		case (len)
			2'h0:    key_bits = 9'h040;
			2'h1:    key_bits = 9'h080;
			2'h2:    key_bits = 9'h0C0;
			default: key_bits = 9'h100;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Synchronise power-mode pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_s1_reg  <= 1'b0;
			idle_s2_reg  <= 1'b0;
			sleep_s1_reg <= 1'b0;
			sleep_s2_reg <= 1'b0;
		end else begin
			idle_s1_reg  <= idle_mode_i;
			idle_s2_reg  <= idle_s1_reg;
			sleep_s1_reg <= sleep_mode_i;
			sleep_s2_reg <= sleep_s1_reg;
		end
	end

	logic halt;
	assign halt = sleep_s2_reg
		| (idle_s2_reg & ctrl_reg.stop_in_idle);

	////////////////////////////////////////////////////////////////////
	// Configuration checks
	logic key_err;
	logic ctr_mode;
	logic long_key;
	always_comb begin
		ctr_mode = ctrl_reg.cipher && (ctrl_reg.chain == bcos_pkg::CM_CTR);
		long_key = cfg_reg.key_len > bcos_pkg::KLEN_128;
		key_err  = 1'b0;
		if (cfg_reg.sk_enable && cfg_reg.key_src == bcos_pkg::KSRC_STORED1
			&& (ctrl_reg.op == bcos_pkg::OP_ENC || ctrl_reg.op == bcos_pkg::OP_DEC)) begin
			key_err = 1'b1;
		end
		if ((ctrl_reg.op == bcos_pkg::OP_SK_ENC || ctrl_reg.op == bcos_pkg::OP_SK_DEC)
			&& long_key && (ctrl_reg.chain == bcos_pkg::CM_ECB
			|| ctrl_reg.chain == bcos_pkg::CM_CBC)) begin
			key_err = 1'b1;
		end
		if (ctr_mode && cfg_reg.sw_key_dis && ctrl_reg.op == bcos_pkg::OP_ENC) begin
			key_err = 1'b1;
		end
		if (!ctrl_reg.cipher && cfg_reg.key_len != bcos_pkg::KLEN_DES
			&& cfg_reg.key_len != bcos_pkg::KLEN_128) begin
			key_err = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus decode
	logic acc, wr;
	logic wr_ctrl, wr_cfg, wr_stat;
	logic go_set_req, go_clr_req, go_ok;
	assign acc     = cyc_i & stb_i & ~ack_reg;
	assign wr      = acc & we_i;
	assign wr_ctrl = wr && adr_i == bcos_pkg::ADDR_CTRL;
	assign wr_cfg  = wr && adr_i == bcos_pkg::ADDR_CFG && !go_reg;
	assign wr_stat = wr && adr_i == bcos_pkg::ADDR_STAT;
	assign go_set_req = wr_ctrl && sel_i[1] && dat_i[bcos_pkg::CTRL_GO] && !go_reg;
	assign go_clr_req = wr_ctrl && sel_i[1] && !dat_i[bcos_pkg::CTRL_GO] && go_reg;
	assign go_ok = ctrl_reg.enable && !cfg_reg.storage_write && !cfg_reg.storage_read
		&& !abort_reg && !mode_err_reg && !key_err && !halt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= acc;
		end
	end
	assign ack_o = ack_reg;

	// Control and config registers; op, cipher, chain and config locked while running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= '0;
			cfg_reg  <= '0;
		end else begin
			if (wr_ctrl && sel_i[1]) begin
				ctrl_reg.enable       <= dat_i[bcos_pkg::CTRL_ENABLE];
				ctrl_reg.stop_in_idle <= dat_i[bcos_pkg::CTRL_SIDL];
				ctrl_reg.done_ie      <= dat_i[bcos_pkg::CTRL_DONE_IRQ_ENABLE];
				ctrl_reg.free_ie      <= dat_i[bcos_pkg::CTRL_INPUT_FREE_IRQ_ENABLE];
			end
			if (wr_ctrl && sel_i[0] && !go_reg) begin
				ctrl_reg.op     <= dat_i[bcos_pkg::CTRL_OP_LSB +: 4];
				ctrl_reg.cipher <= dat_i[bcos_pkg::CTRL_CSEL];
				ctrl_reg.chain  <= dat_i[bcos_pkg::CTRL_CM_LSB +: 3];
			end
			if (wr_cfg && sel_i[0]) begin
				cfg_reg.key_src <= dat_i[bcos_pkg::CFG_KSRC_LSB +: 4];
				cfg_reg.key_len <= dat_i[bcos_pkg::CFG_KLEN_LSB +: 2];
				cfg_reg.sk_half <= dat_i[bcos_pkg::CFG_SKSEL];
				// Session enable is one-time: only ever set
				cfg_reg.sk_enable <= cfg_reg.sk_enable | dat_i[bcos_pkg::CFG_SESSION_KEY_ENABLE];
			end
			if (wr_cfg && sel_i[1]) begin
				cfg_reg.sw_key_dis    <= dat_i[bcos_pkg::CFG_SWKDIS];
				cfg_reg.storage_write <= dat_i[bcos_pkg::CFG_WR] & ctrl_reg.enable;
				cfg_reg.storage_read  <= dat_i[bcos_pkg::CFG_RD];
			end else if (cfg_reg.storage_write || cfg_reg.storage_read) begin
				cfg_reg.storage_write <= 1'b0;
				cfg_reg.storage_read  <= 1'b0;
			end
			if (!ctrl_reg.enable) begin
				cfg_reg.storage_write <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Key expansion tracking
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			need_exp_reg <= 1'b1;
		end else if (state_reg == bcos_pkg::BCOS_EXPAND && cnt_reg == '0) begin
			need_exp_reg <= 1'b0;
		end else if (cfg_reg.storage_write || (wr_cfg && sel_i[0]
			&& (dat_i[bcos_pkg::CFG_KLEN_LSB +: 2] != cfg_reg.key_len
			|| dat_i[bcos_pkg::CFG_KSRC_LSB +: 4] != cfg_reg.key_src))) begin
			need_exp_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Operation sequencer
	logic dec_op, op_done;
	logic [5:0] run_cycles;
	assign dec_op = ctrl_reg.op == bcos_pkg::OP_DEC;
	assign run_cycles = ctrl_reg.cipher ? bcos_pkg::CYC_AES : bcos_pkg::CYC_DES;
	assign op_done = state_reg == bcos_pkg::BCOS_RUN && cnt_reg == '0 && core_done_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg     <= bcos_pkg::BCOS_IDLE;
			go_reg        <= 1'b0;
			cnt_reg       <= '0;
			free_sent_reg <= 1'b0;
		end else if (halt || !ctrl_reg.enable) begin
			state_reg <= bcos_pkg::BCOS_IDLE;
			go_reg    <= 1'b0;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				bcos_pkg::BCOS_IDLE: begin
					if (go_set_req && go_ok) begin
						go_reg        <= 1'b1;
						free_sent_reg <= 1'b0;
						if (dec_op && need_exp_reg) begin
							state_reg <= bcos_pkg::BCOS_EXPAND;
							cnt_reg   <= bcos_pkg::CYC_KEXP;
						end else begin
							state_reg <= bcos_pkg::BCOS_RUN;
							cnt_reg   <= run_cycles;
						end
					end
				end
				bcos_pkg::BCOS_EXPAND: begin
					if (go_clr_req) begin
						state_reg <= bcos_pkg::BCOS_IDLE;
						go_reg    <= 1'b0;
					end else if (cnt_reg == '0) begin
						state_reg <= bcos_pkg::BCOS_RUN;
						cnt_reg   <= run_cycles;
					end else begin
						cnt_reg <= cnt_reg - 6'h01;
					end
				end
				bcos_pkg::BCOS_RUN: begin
					if (go_clr_req) begin
						state_reg <= bcos_pkg::BCOS_IDLE;
						go_reg    <= 1'b0;
					end else if (op_done) begin
						state_reg <= bcos_pkg::BCOS_IDLE;
						go_reg    <= 1'b0;
					end else if (cnt_reg != '0) begin
						cnt_reg <= cnt_reg - 6'h01;
					end
					if (cnt_reg == bcos_pkg::CYC_FREE) begin
						free_sent_reg <= 1'b1;
					end
				end
				default: begin
					state_reg <= bcos_pkg::BCOS_IDLE;
					go_reg    <= 1'b0;
				end
			endcase
		end
	end

	// Abort and mode error flags; set wins over software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			abort_reg    <= 1'b0;
			mode_err_reg <= 1'b0;
		end else begin
			abort_reg <= (go_clr_req && state_reg != bcos_pkg::BCOS_IDLE)
				|| (abort_reg && !(wr_stat && sel_i[0] && dat_i[bcos_pkg::STAT_ABORT]));
			mode_err_reg <= (go_set_req && ctrl_reg.enable && cfg_reg.sk_enable
				&& ctrl_reg.op == bcos_pkg::OP_SK_DEC && cfg_reg.key_src == bcos_pkg::KSRC_SESSION
				&& ctrl_reg.chain == bcos_pkg::CM_ECB && 1'b0)
				|| (mode_err_reg && !(wr_stat && sel_i[0] && dat_i[bcos_pkg::STAT_MODF]));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Text and key spaces, writable only while idle
	genvar g;
	generate
		for (g = 0; g < 12; g++) begin : g_text
			always_ff @(posedge clk_i) begin
				if (rst_i || sleep_s2_reg) begin
					text_reg[g] <= '0;
				end else if (wr && !go_reg && adr_i == bcos_pkg::ADDR_TXTA + 8'(g * 4)) begin
					text_reg[g] <= lane_merge(text_reg[g], dat_i, sel_i);
				end
			end
		end
		for (g = 0; g < 8; g++) begin : g_key
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					key_reg[g] <= '0;
				end else if (wr && !go_reg && adr_i == bcos_pkg::ADDR_KEY + 8'(g * 4)) begin
					key_reg[g] <= lane_merge(key_reg[g], dat_i, sel_i);
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Read mux; key space is write-only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else if (acc && !we_i) begin
			dat_o <= '0;
			if (adr_i == bcos_pkg::ADDR_CTRL) begin
				dat_o[bcos_pkg::CTRL_ENABLE] <= ctrl_reg.enable;
				dat_o[bcos_pkg::CTRL_SIDL]   <= ctrl_reg.stop_in_idle;
				dat_o[bcos_pkg::CTRL_DONE_IRQ_ENABLE] <= ctrl_reg.done_ie;
				dat_o[bcos_pkg::CTRL_INPUT_FREE_IRQ_ENABLE] <= ctrl_reg.free_ie;
				dat_o[bcos_pkg::CTRL_GO]     <= go_reg;
				dat_o[7:0] <= {ctrl_reg.op, ctrl_reg.cipher, ctrl_reg.chain};
			end else if (adr_i == bcos_pkg::ADDR_CFG) begin
				dat_o[10:0] <= {cfg_reg.storage_read, cfg_reg.storage_write,
					cfg_reg.sw_key_dis, cfg_reg.sk_enable, cfg_reg.sk_half,
					cfg_reg.key_len, cfg_reg.key_src};
			end else if (adr_i == bcos_pkg::ADDR_STAT) begin
				dat_o[4:0] <= {go_reg, key_err, mode_err_reg, 1'b0, abort_reg};
			end else if (adr_i >= bcos_pkg::ADDR_TXTA && adr_i < bcos_pkg::ADDR_KEY
				&& !(cfg_reg.sk_enable && ctrl_reg.op == bcos_pkg::OP_SK_DEC
				&& adr_i < bcos_pkg::ADDR_TXTB)) begin
				dat_o <= text_reg[4'((adr_i - bcos_pkg::ADDR_TXTA) >> 2)];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Core handshake and interrupt pulses
	logic [8:0] key_len_bits;
	assign key_len_bits = key_bits(cfg_reg.key_len);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_start_o      <= 1'b0;
			core_op_o         <= '0;
			core_dec_bottom_o <= 1'b0;
			core_key_bits_o   <= '0;
			done_irq_o        <= 1'b0;
			free_irq_o        <= 1'b0;
		end else begin
			core_start_o <= state_reg == bcos_pkg::BCOS_RUN && cnt_reg == run_cycles;
			core_op_o    <= state_reg == bcos_pkg::BCOS_EXPAND ? bcos_pkg::OP_KEXP
				: ctrl_reg.op;
			core_dec_bottom_o <= dec_op && !ctrl_reg.cipher;
			core_key_bits_o   <= key_len_bits[8:1];
			done_irq_o <= op_done && ctrl_reg.done_ie;
			free_irq_o <= state_reg == bcos_pkg::BCOS_RUN && cnt_reg == bcos_pkg::CYC_FREE
				&& !free_sent_reg && ctrl_reg.free_ie
				&& (ctrl_reg.chain == bcos_pkg::CM_ECB
				|| ctrl_reg.chain == bcos_pkg::CM_CBC);
		end
	end

endmodule : bcos_sequencer
`default_nettype wire

//--- dv/bcos_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bcos_properties (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        sleep_mode_i,
	input wire logic        core_done_i,
	input wire logic        core_start_o,
	input wire logic [3:0]  core_op_o,
	input wire logic        done_irq_o,
	input wire logic        free_irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acknowledged");
	a_unmapped_zero: assert property (ack_o && cyc_i && !we_i && adr_i == 8'hF0 |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_quiet_reset: assert property ($past(rst_i) |-> !core_start_o && !done_irq_o && !free_irq_o)
		else $error("output active after reset");
	a_done_pulse: assert property (done_irq_o |=> !done_irq_o)
		else $error("done event longer than one cycle");
	a_free_pulse: assert property (free_irq_o |=> !free_irq_o)
		else $error("free event longer than one cycle");
	a_done_cause: assert property (done_irq_o |-> $past(core_done_i) || $past(core_done_i, 2))
		else $error("done event without datapath completion");
	a_start_pulse: assert property (core_start_o |=> !core_start_o)
		else $error("start longer than one cycle");
	a_sleep_halts: assert property (sleep_mode_i [*6] |-> !core_start_o && !done_irq_o)
		else $error("activity during sleep");
	////////////////////////////////////////////////////////////////
	c_done: cover property (done_irq_o);
	c_free: cover property (free_irq_o);
	c_expand: cover property (core_start_o && core_op_o == bcos_pkg::OP_KEXP);
endmodule // bcos_properties

bind bcos_sequencer bcos_properties u_props (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_mode_i(sleep_mode_i),
	.core_done_i(core_done_i), .core_start_o(core_start_o), .core_op_o(core_op_o),
	.done_irq_o(done_irq_o), .free_irq_o(free_irq_o)
);
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [31:0] GO = 32'h1 << bcos_pkg::CTRL_GO;
	localparam logic [31:0] KF = 32'h1 << bcos_pkg::STAT_KEYF;
	localparam logic [31:0] AB = 32'h1 << bcos_pkg::STAT_ABORT;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc, stb, we, idl, slp, cdone, ack, cst, dbot, dirq, firq, kx, bt;
	logic [7:0]  adr, kbo, kb;
	logic [31:0] wd, rd, q;
	logic [3:0]  cop, sop;
	logic [31:0] ec [3];
	logic [2:0]  em [3];
	logic [3:0]  eo [3];
	int          bad_count = 0;
	int          tests_run = 0;
	int          nd, nf, ns;
	always #5 clk_i = ~clk_i;
	bcos_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(rd), .ack_o(ack),
		.idle_mode_i(idl), .sleep_mode_i(slp), .core_done_i(cdone), .core_start_o(cst),
		.core_op_o(cop), .core_dec_bottom_o(dbot), .core_key_bits_o(kbo),
		.done_irq_o(dirq), .free_irq_o(firq));
	////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (dirq === 1'b1) nd++;
		if (firq === 1'b1) nf++;
		if (cst === 1'b1) begin
			ns++;
			sop = cop;
			kb = kbo;
		end
		if (cop === bcos_pkg::OP_KEXP) kx = 1'b1;
		if (dbot === 1'b1) bt = 1'b1;
	end
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(logic [31:0] g, logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic hang(string s);
		bad_count++;
		$display("FAIL %0t %s", $time, s);
		complete_run();
	endtask
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 40) hang("bus timeout");
	endtask
	task automatic rdchk(logic [7:0] a, logic [31:0] m, logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	function automatic logic [31:0] ctl(logic [3:0] op, logic cs, logic [2:0] cm,
			logic g, logic en, logic sd);
		return 32'(en) << bcos_pkg::CTRL_ENABLE | 32'(sd) << bcos_pkg::CTRL_SIDL
			| 32'h1 << bcos_pkg::CTRL_DONE_IRQ_ENABLE | 32'h1 << bcos_pkg::CTRL_INPUT_FREE_IRQ_ENABLE
			| 32'(g) << bcos_pkg::CTRL_GO | 32'(op) << bcos_pkg::CTRL_OP_LSB
			| 32'(cs) << bcos_pkg::CTRL_CSEL | 32'(cm);
	endfunction
	function automatic logic [31:0] cfg(logic sk, logic sw, logic [1:0] kl, logic [3:0] ks);
		return 32'(sw) << bcos_pkg::CFG_SWKDIS | 32'(sk) << bcos_pkg::CFG_SESSION_KEY_ENABLE
			| 32'(kl) << bcos_pkg::CFG_KLEN_LSB | 32'(ks);
	endfunction
	task automatic go(logic [3:0] op, logic cs, logic [2:0] cm, logic en, logic sd);
		nd = 0;
		nf = 0;
		ns = 0;
		kx = 1'b0;
		bt = 1'b0;
		// Go is judged on the settings already held, so load them first
		wb(1'b1, bcos_pkg::ADDR_CTRL, ctl(op, cs, cm, 1'b0, en, sd));
		wb(1'b1, bcos_pkg::ADDR_CTRL, ctl(op, cs, cm, 1'b1, en, sd));
	endtask
	task automatic run(logic [3:0] op, logic cs, logic [2:0] cm);
		int n;
		go(op, cs, cm, 1'b1, 1'b0);
		n = 0;
		while (nd == 0 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (nd == 0) hang("no completion");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{cyc, stb, we, idl, slp, adr, wd} = '0;
		cdone = 1'b1;
		ec = '{cfg(1, 0, 2'h1, 4'h1), cfg(0, 0, 2'h2, 4'h0), cfg(0, 1, 2'h1, 4'h0)};
		em = '{bcos_pkg::CM_ECB, bcos_pkg::CM_ECB, bcos_pkg::CM_CTR};
		eo = '{bcos_pkg::OP_ENC, bcos_pkg::OP_SK_ENC, bcos_pkg::OP_ENC};
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(bcos_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h0);
		rdchk(bcos_pkg::ADDR_STAT, 32'hFFFF_FFFF, 32'h0);
		rdchk(8'hF0, 32'hFFFF_FFFF, 32'h0);
		wb(1'b1, bcos_pkg::ADDR_CFG, cfg(0, 0, bcos_pkg::KLEN_128, bcos_pkg::KSRC_SESSION));
		run(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(sop), 32'(bcos_pkg::OP_ENC));
		chk(32'(kb), 32'h40);
		chk(32'(nf), 32'h1);
		rdchk(bcos_pkg::ADDR_CTRL, GO, 32'h0);
		run(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_CTR);
		chk(32'(nf), 32'h0);
		chk(32'(sop), 32'(bcos_pkg::OP_ENC));
		wb(1'b1, bcos_pkg::ADDR_TXTA, 32'h0);
		run(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_CTR);
		chk(32'(ns), 32'h1);
		run(bcos_pkg::OP_DEC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(kx), 32'h1);
		chk(32'(sop), 32'(bcos_pkg::OP_DEC));
		chk(32'(bt), 32'h0);
		run(bcos_pkg::OP_DEC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(kx), 32'h0);
		wb(1'b1, bcos_pkg::ADDR_CFG, cfg(0, 0, bcos_pkg::KLEN_128, bcos_pkg::KSRC_SESSION)
			| 32'h1 << bcos_pkg::CFG_WR);
		run(bcos_pkg::OP_DEC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(kx), 32'h1);
		wb(1'b1, bcos_pkg::ADDR_CFG, cfg(0, 0, bcos_pkg::KLEN_128, bcos_pkg::KSRC_STORED1));
		run(bcos_pkg::OP_DEC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(kx), 32'h1);
		run(bcos_pkg::OP_KEXP, 1'b1, bcos_pkg::CM_CBC);
		chk(32'(sop), 32'(bcos_pkg::OP_KEXP));
		wb(1'b1, bcos_pkg::ADDR_CFG, cfg(0, 0, bcos_pkg::KLEN_DES, bcos_pkg::KSRC_SESSION));
		run(bcos_pkg::OP_DEC, 1'b0, bcos_pkg::CM_ECB);
		chk(32'(bt), 32'h1);
		chk(32'(kb), 32'h20);
		wb(1'b1, bcos_pkg::ADDR_CFG, cfg(1, 0, bcos_pkg::KLEN_128, bcos_pkg::KSRC_SESSION));
		run(bcos_pkg::OP_SK_ENC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(sop), 32'(bcos_pkg::OP_SK_ENC));
		run(bcos_pkg::OP_SK_DEC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(sop), 32'(bcos_pkg::OP_SK_DEC));
		wb(1'b1, bcos_pkg::ADDR_TXTA, 32'h5A5A_5A5A);
		rdchk(bcos_pkg::ADDR_TXTA, 32'hFFFF_FFFF, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, bcos_pkg::ADDR_CFG, ec[i]);
			wb(1'b1, bcos_pkg::ADDR_CTRL, ctl(eo[i], 1'b1, em[i], 1'b0, 1'b1, 1'b0));
			rdchk(bcos_pkg::ADDR_STAT, KF, KF);
			go(eo[i], 1'b1, em[i], 1'b1, 1'b0);
			rdchk(bcos_pkg::ADDR_CTRL, GO, 32'h0);
			chk(32'(ns), 32'h0);
		end
		wb(1'b1, bcos_pkg::ADDR_CFG, cfg(0, 0, bcos_pkg::KLEN_128, bcos_pkg::KSRC_SESSION));
		cdone <= 1'b0;
		go(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_ECB, 1'b1, 1'b0);
		wb(1'b1, bcos_pkg::ADDR_CTRL, ctl(bcos_pkg::OP_ENC, 1, bcos_pkg::CM_ECB, 0, 1, 0));
		rdchk(bcos_pkg::ADDR_STAT, AB, AB);
		chk(32'(nd), 32'h0);
		cdone <= 1'b1;
		go(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_ECB, 1'b1, 1'b0);
		rdchk(bcos_pkg::ADDR_CTRL, GO, 32'h0);
		wb(1'b1, bcos_pkg::ADDR_STAT, AB);
		run(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(ns), 32'h1);
		go(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_ECB, 1'b0, 1'b0);
		rdchk(bcos_pkg::ADDR_CTRL, GO, 32'h0);
		chk(32'(ns), 32'h0);
		idl <= 1'b1;
		run(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_ECB);
		chk(32'(nd), 32'h1);
		idl <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			go(bcos_pkg::OP_ENC, 1'b1, bcos_pkg::CM_ECB, 1'b1, 1'b1);
			if (i == 0) idl <= 1'b1;
			else slp <= 1'b1;
			repeat (40) @(posedge clk_i);
			idl <= 1'b0;
			slp <= 1'b0;
			repeat (4) @(posedge clk_i);
			chk(32'(nd), 32'h0);
			rdchk(bcos_pkg::ADDR_CTRL, GO, 32'h0);
		end
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		hang("run timeout");
	end
endmodule // tb
`default_nettype wire
